//--- logic/fpvs_sequencer.sv
// host sequencer that programs one flash page with the program/verify loop
//
// Overview of operation
// - flash array gives no read data while programming; sequencer runs outside it.
// - only erased locations are programmed, never programmed ones again.
// - after write enable and its delay, write 128 bytes consecutively as bytes.
// - page start address has low eight bits 00 or 80.
// - short pages are padded to 128 bytes with FF.
// - arm watchdog before the pulse, longer than all pulse-related waits together.
// - set setup, wait, then set pulse; pulse lasts while pulse bit set.
// - clear pulse, wait, clear setup; watchdog released after leaving program mode.
// - verify: wait, dummy-write FF, wait, then read latched address data.
// - verify reads are 16-bit word accesses.
// - after 128 bytes verified: leave verify, wait, drop write enable, wait; N loops max.
// - bits still reading one get another pulse until all zero targets read zero.
// - bits first passing in loops one to six get one additional pulse.
// - pulse width 30 for loops 1-6, 200 from loop 7, 10 additional.
// - a passed bit that reads one again is pulsed again.
// - control bits never toggled from code fetched out of the flash array.
// - separate 128-byte reprogram and additional-programming buffers are kept.
// - reprogram bit zero only when source is zero and verify reads one.
// - additional bit zero only when reprogram is zero and verify reads zero.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module fpvs_sequencer
	import fpvs_pkg::*;
#(
	parameter int MAX_LOOPS = 1000,
	parameter int RD_LAT    = 2
) (
	// clock and reset
	input  wire logic                clock,
	input  wire logic                nrst,
	// software port
	input  wire logic [8:0]          sw_addr,
	input  wire logic [31:0]         sw_wdata,
	input  wire logic                sw_wr,
	input  wire logic                sw_rd,
	output logic      [31:0]         sw_rdata,
	// flash control bits and pins
	output logic                     sw_write_enable,
	output logic                     program_setup,
	output logic                     program_pulse,
	output logic                     program_verify,
	output logic                     erase_setup,
	output logic                     erase_verify,
	output logic                     flash_write_enable_pin,
	output logic                     watchdog_timer_arm,
	output logic      [15:0]         watchdog_timer_period,
	// flash memory bus
	output logic      [16:0]         fl_addr,
	output logic      [7:0]          fl_wdata,
	output logic                     fl_wr,
	output logic                     fl_rd_word,
	input  wire logic [15:0]         fl_rdata
);
	import fpvs_pkg::*;

	// ------------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------------
	if (MAX_LOOPS < 1 || MAX_LOOPS > 65535) begin : g_bad_loops
		$error("MAX_LOOPS must lie in 1..65535");
	end
	if (RD_LAT < 0 || RD_LAT > 1000) begin : g_bad_lat
		$error("RD_LAT must lie in 0..1000");
	end

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		fpvs_state_t          st;
		logic [15:0]          wait_cnt;
		logic [6:0]           idx;
		logic [15:0]          loop;
		logic                 add_phase;
		logic                 incomplete;
		logic [16:0]          page;
		logic [7:0]           count;
		logic                 busy;
		logic                 done;
		logic                 fail;
		logic                 badadr;
		logic [31:0]          rdata;
		logic                 wen;
		logic                 setup;
		logic                 pls;
		logic                 vfy;
		logic                 pin_en;
		logic                 wdog;
		logic [16:0]          faddr;
		logic [7:0]           fwd;
		logic                 fwr;
		logic                 frd;
		logic [127:0][7:0]    src;
		logic [127:0][7:0]    rep;
		logic [127:0][7:0]    add;
	} fpvs_regs_t;

	fpvs_regs_t q;
	fpvs_regs_t d;
	logic [15:0] rdata_s;
	logic [7:0]  eff_count;
	logic [15:0] pulse_cyc;

	// pin data passes two flops before use
	fpvs_sync #(.W(16)) u_rsync (
		.clock (clock),
		.nrst  (nrst),
		.din   (fl_rdata),
		.dout  (rdata_s)
	);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [7:0] v;
		logic [7:0] nrep;
		logic [6:0] bi;
		d = q;
		v = 8'h00;
		nrep = 8'h00;
		bi = 7'h00;
		eff_count = (q.count == 8'h00 || q.count > 8'(PAGE_BYTES)) ? 8'(PAGE_BYTES) : q.count;
		if (q.add_phase) begin
			pulse_cyc = 16'(C_SP_ADD);
		end else if (q.loop <= 16'(EARLY_LOOPS)) begin
			pulse_cyc = 16'(C_SP_EARLY);
		end else begin
			pulse_cyc = 16'(C_SP_LATE);
		end
		d.fwr = 1'b0;
		d.frd = 1'b0;
		d.rdata = 32'h0000_0000;

		// software port
		if (sw_rd) begin
			if (sw_addr[DATA_SEL_BIT]) begin
				d.rdata = {24'h000000, q.src[sw_addr[6:0]]};
			end else begin
				unique case (sw_addr)
					REG_PAGE:   d.rdata = {15'h0000, q.page};
					REG_COUNT:  d.rdata = {24'h000000, q.count};
					REG_STATUS: begin
						d.rdata[ST_BUSY_BIT]   = q.busy;
						d.rdata[ST_DONE_BIT]   = q.done;
						d.rdata[ST_FAIL_BIT]   = q.fail;
						d.rdata[ST_BADADR_BIT] = q.badadr;
						d.rdata[ST_LOOP_LSB +: 16] = q.loop;
					end
					default:    d.rdata = 32'h0000_0000;
				endcase
			end
		end
		if (sw_wr && !q.busy) begin
			if (sw_addr[DATA_SEL_BIT]) begin
				d.src[sw_addr[6:0]] = sw_wdata[7:0];
			end else if (sw_addr == REG_PAGE) begin
				d.page = sw_wdata[16:0] & FLASH_TOP;
			end else if (sw_addr == REG_COUNT) begin
				d.count = sw_wdata[7:0];
			end else if (sw_addr == REG_CTRL && sw_wdata[CTRL_START_BIT]) begin
				d.done = 1'b0;
				d.fail = 1'b0;
				if (q.page[6:0] != 7'h00) begin
					d.badadr = 1'b1;
				end else begin
					d.badadr = 1'b0;
					d.busy = 1'b1;
					d.loop = 16'h0001;
					d.add_phase = 1'b0;
					for (int i = 0; i < PAGE_BYTES; i++) begin
						if (8'(i) >= eff_count) begin
							d.src[i] = BYTE_ERASED;
						end
					end
					d.rep = d.src;
					d.add = {PAGE_BYTES{BYTE_ERASED}};
					d.pin_en = 1'b1;
					d.wen = 1'b1;
					d.wait_cnt = 16'(C_SSWE - 1);
					d.st = S_WEN_ON;
				end
			end
		end

		// sequencer
		if (q.wait_cnt != 16'h0000) begin
			d.wait_cnt = q.wait_cnt - 16'h0001;
		end else begin
			unique case (q.st)
				S_IDLE: begin
				end
				S_WEN_ON: begin
					d.idx = 7'h00;
					d.st = S_XFER;
				end
				S_XFER: begin
					d.faddr = q.page + 17'(q.idx);
					d.fwd = q.add_phase ? q.add[q.idx] : q.rep[q.idx];
					d.fwr = 1'b1;
					d.wait_cnt = 16'h0001;
					d.idx = q.idx + 7'h01;
					if (q.idx == 7'(PAGE_BYTES - 1)) begin
						d.st = S_SETUP;
					end
				end
				S_SETUP: begin
					d.wdog = 1'b1;
					d.setup = 1'b1;
					d.wait_cnt = 16'(C_SPSU - 1);
					d.st = S_PULSE;
				end
				S_PULSE: begin
					d.pls = q.setup & q.wen & q.pin_en;
					d.wait_cnt = pulse_cyc - 16'h0001;
					d.st = S_PEND;
				end
				S_PEND: begin
					d.pls = 1'b0;
					d.wait_cnt = 16'(C_CP - 1);
					d.st = S_PSUOFF;
				end
				S_PSUOFF: begin
					d.setup = 1'b0;
					d.wait_cnt = 16'(C_CPSU - 1);
					d.st = q.add_phase ? S_SWEOFF : S_PVON;
				end
				S_PVON: begin
					d.wdog = 1'b0;
					d.vfy = 1'b1;
					d.idx = 7'h00;
					d.incomplete = 1'b0;
					d.wait_cnt = 16'(C_SPV - 1);
					d.st = S_DUMMY;
				end
				S_DUMMY: begin
					d.faddr = q.page + 17'(q.idx);
					d.fwd = BYTE_ERASED;
					d.fwr = 1'b1;
					d.wait_cnt = 16'(C_SPVR);
					d.st = S_READ;
				end
				S_READ: begin
					d.frd = 1'b1;
					d.wait_cnt = 16'(RD_LAT + 2);
					d.st = S_TAKE;
				end
				S_TAKE: begin
					for (int b = 0; b < 2; b++) begin
						bi = q.idx + 7'(b);
						v = (b == 0) ? rdata_s[15:8] : rdata_s[7:0];
						nrep = q.src[bi] | ~v;
						d.rep[bi] = nrep;
						d.add[bi] = q.rep[bi] | v;
						if (nrep != BYTE_ERASED) begin
							d.incomplete = 1'b1;
						end
					end
					d.idx = q.idx + 7'h02;
					d.st = (q.idx == 7'(PAGE_BYTES - 2)) ? S_PVOFF : S_DUMMY;
				end
				S_PVOFF: begin
					d.vfy = 1'b0;
					d.wait_cnt = 16'(C_CPV - 1);
					if (q.loop <= 16'(EARLY_LOOPS)) begin
						d.add_phase = 1'b1;
						d.idx = 7'h00;
						d.st = S_XFER;
					end else begin
						d.st = S_SWEOFF;
					end
				end
				S_SWEOFF: begin
					d.wdog = 1'b0;
					d.wen = 1'b0;
					d.add_phase = 1'b0;
					d.wait_cnt = 16'(C_CSWE - 1);
					d.st = S_DECIDE;
				end
				S_DECIDE: begin
					if (!q.incomplete) begin
						d.done = 1'b1;
						d.busy = 1'b0;
						d.pin_en = 1'b0;
						d.st = S_IDLE;
					end else if (q.loop >= 16'(MAX_LOOPS)) begin
						d.fail = 1'b1;
						d.busy = 1'b0;
						d.pin_en = 1'b0;
						d.st = S_IDLE;
					end else begin
						d.loop = q.loop + 16'h0001;
						d.wen = 1'b1;
						d.wait_cnt = 16'(C_SSWE - 1);
						d.st = S_WEN_ON;
					end
				end
				default: begin
					d.st = S_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.st <= S_IDLE;
			q.page <= PAGE_RESET;
			q.count <= COUNT_RESET;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign sw_rdata               = q.rdata;
	assign sw_write_enable        = q.wen;
	assign program_setup          = q.setup;
	assign program_pulse          = q.pls;
	assign program_verify         = q.vfy;
	assign erase_setup            = 1'b0;
	assign erase_verify           = 1'b0;
	assign flash_write_enable_pin = q.pin_en;
	assign watchdog_timer_arm     = q.wdog;
	assign watchdog_timer_period  = 16'(C_WDOG);
	assign fl_addr                = q.faddr;
	assign fl_wdata               = q.fwd;
	assign fl_wr                  = q.fwr;
	assign fl_rd_word             = q.frd;

endmodule

//--- logic/fpvs_pkg.sv
// constants, register map and state codes of the flash program/verify sequencer
package fpvs_pkg;

	// ------------------------------------------------------------------
	// clock and wait times
	// ------------------------------------------------------------------
	localparam int CLK_MHZ       = 20;
	localparam int T_SSWE_US     = 1;
	localparam int T_SPSU_US     = 50;
	localparam int T_SP_EARLY_US = 30;
	localparam int T_SP_LATE_US  = 200;
	localparam int T_SP_ADD_US   = 10;
	localparam int T_CP_US       = 5;
	localparam int T_CPSU_US     = 5;
	localparam int T_SPV_US      = 4;
	localparam int T_SPVR_US     = 2;
	localparam int T_CPV_US      = 2;
	localparam int T_CSWE_US     = 100;
	localparam int T_WDOG_US     = T_SPSU_US + T_SP_LATE_US + T_CP_US + T_CPSU_US + 10;

	localparam int C_SSWE     = T_SSWE_US * CLK_MHZ;
	localparam int C_SPSU     = T_SPSU_US * CLK_MHZ;
	localparam int C_SP_EARLY = T_SP_EARLY_US * CLK_MHZ;
	localparam int C_SP_LATE  = T_SP_LATE_US * CLK_MHZ;
	localparam int C_SP_ADD   = T_SP_ADD_US * CLK_MHZ;
	localparam int C_CP       = T_CP_US * CLK_MHZ;
	localparam int C_CPSU     = T_CPSU_US * CLK_MHZ;
	localparam int C_SPV      = T_SPV_US * CLK_MHZ;
	localparam int C_SPVR     = T_SPVR_US * CLK_MHZ;
	localparam int C_CPV      = T_CPV_US * CLK_MHZ;
	localparam int C_CSWE     = T_CSWE_US * CLK_MHZ;
	localparam int C_WDOG     = T_WDOG_US * CLK_MHZ;

	// ------------------------------------------------------------------
	// page and algorithm figures
	// ------------------------------------------------------------------
	localparam int       PAGE_BYTES  = 128;
	localparam int       EARLY_LOOPS = 6;
	localparam logic [7:0] BYTE_ERASED = 8'hff;
	localparam logic [16:0] FLASH_TOP  = 17'h1ffff;

	// ------------------------------------------------------------------
	// software register map (word index on sw_addr)
	// ------------------------------------------------------------------
	localparam logic [8:0] REG_CTRL   = 9'h000;
	localparam logic [8:0] REG_PAGE   = 9'h001;
	localparam logic [8:0] REG_COUNT  = 9'h002;
	localparam logic [8:0] REG_STATUS = 9'h003;
	localparam int         DATA_SEL_BIT   = 8;
	localparam int         CTRL_START_BIT = 0;
	localparam int         ST_BUSY_BIT    = 0;
	localparam int         ST_DONE_BIT    = 1;
	localparam int         ST_FAIL_BIT    = 2;
	localparam int         ST_BADADR_BIT  = 3;
	localparam int         ST_LOOP_LSB    = 16;
	localparam logic [16:0] PAGE_RESET    = 17'h00000;
	localparam logic [7:0]  COUNT_RESET   = 8'h00;

	// ------------------------------------------------------------------
	// sequencer states, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [13:0] {
		S_IDLE   = 14'h0001,
		S_WEN_ON = 14'h0002,
		S_XFER   = 14'h0004,
		S_SETUP  = 14'h0008,
		S_PULSE  = 14'h0010,
		S_PEND   = 14'h0020,
		S_PSUOFF = 14'h0040,
		S_PVON   = 14'h0080,
		S_DUMMY  = 14'h0100,
		S_READ   = 14'h0200,
		S_TAKE   = 14'h0400,
		S_PVOFF  = 14'h0800,
		S_SWEOFF = 14'h1000,
		S_DECIDE = 14'h2000
	} fpvs_state_t;

endpackage

//--- logic/fpvs_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module fpvs_sync #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         nrst,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end

endmodule

//--- dv/fpvs_chk.sv
// port-level assertions for the flash program/verify sequencer
`timescale 1ns/1ps
module fpvs_chk (
	// clock and reset
	input wire logic        clock,
	input wire logic        nrst,
	// flash control
	input wire logic        sw_write_enable,
	input wire logic        program_setup,
	input wire logic        program_pulse,
	input wire logic        program_verify,
	input wire logic        erase_setup,
	input wire logic        erase_verify,
	input wire logic        flash_write_enable_pin,
	input wire logic        watchdog_timer_arm,
	input wire logic [15:0] watchdog_timer_period,
	// flash bus
	input wire logic [16:0] fl_addr,
	input wire logic [7:0]  fl_wdata,
	input wire logic        fl_wr,
	input wire logic        fl_rd_word
);
	import fpvs_pkg::*;
	logic [15:0] setup_n, pul_n, plo_n, wr_n, vfy_n, wen_n;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	function automatic logic [15:0] up(input logic [15:0] v);
		return (v == 16'hffff) ? v : v + 16'h0001;
	endfunction
	// ------------------------------------------------------------------
	// elapsed-time counters
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			setup_n <= '0;
			pul_n <= '0;
			plo_n <= '0;
			wr_n <= '0;
			vfy_n <= '0;
			wen_n <= 16'(C_CSWE);
		end else begin
			setup_n <= (program_setup && !program_pulse) ? up(setup_n) : '0;
			pul_n <= program_pulse ? up(pul_n) : '0;
			plo_n <= !program_pulse ? up(plo_n) : '0;
			wr_n <= !fl_wr ? up(wr_n) : '0;
			vfy_n <= program_verify ? up(vfy_n) : '0;
			wen_n <= !sw_write_enable ? up(wen_n) : '0;
		end
	end
	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	AST_PULSE_GATED: assert property (
		program_pulse |-> program_setup && sw_write_enable && flash_write_enable_pin)
		else $error("pulse without setup or enables");
	AST_SETUP_WAIT: assert property (
		$rose(program_pulse) |-> setup_n >= 16'(C_SPSU)) else $error("setup wait short");
	AST_PULSE_WIDTH: assert property (
		$fell(program_pulse) |-> pul_n inside {C_SP_EARLY, C_SP_LATE, C_SP_ADD})
		else $error("pulse width off");
	AST_CLEAR_WAIT: assert property (
		$fell(program_setup) |-> plo_n >= 16'(C_CP)) else $error("setup cleared early");
	AST_WDT_ARMED: assert property (
		program_pulse |-> watchdog_timer_arm
		&& watchdog_timer_period > 16'(C_SPSU + C_SP_LATE + C_CP + C_CPSU))
		else $error("watchdog not armed");
	AST_WORD_READ: assert property (
		fl_rd_word |-> program_verify && !fl_addr[0] && wr_n >= 16'(C_SPVR))
		else $error("bad verify read");
	AST_DUMMY_FF: assert property (
		fl_wr && program_verify |-> fl_wdata == 8'hff && vfy_n >= 16'(C_SPV))
		else $error("bad dummy write");
	AST_VERIFY_ALONE: assert property (
		program_verify |-> !program_setup && !program_pulse && !watchdog_timer_arm)
		else $error("verify overlaps program");
	AST_XFER_BYTES: assert property (
		fl_wr && !program_verify |-> sw_write_enable && !program_setup ##1 !fl_wr)
		else $error("bad page transfer");
	AST_SWE_REST: assert property (
		$rose(sw_write_enable) |-> wen_n >= 16'(C_CSWE)) else $error("write enable rest short");
	AST_FWE_COVERS: assert property (
		sw_write_enable |-> flash_write_enable_pin) else $error("pin low while enabled");
	AST_NO_ERASE: assert property (
		!erase_setup && !erase_verify) else $error("erase bit raised");
	COV_ADD: cover property ($fell(program_pulse) && pul_n == 16'(C_SP_ADD));
	COV_READ: cover property (fl_rd_word);
	COV_SETUP: cover property ($rose(program_setup));
endmodule

bind fpvs_sequencer fpvs_chk i_fpvs_chk (.clock, .nrst, .sw_write_enable, .program_setup,
	.program_pulse, .program_verify, .erase_setup, .erase_verify, .flash_write_enable_pin,
	.watchdog_timer_arm, .watchdog_timer_period, .fl_addr, .fl_wdata, .fl_wr, .fl_rd_word);

//--- dv/fpvs_flash_model.sv
// flash array with page latches, program pulse and verify word read
`timescale 1ns/1ps
module fpvs_flash_model #(
	parameter int RD_LAT = 2
) (
	// clock
	input  wire logic        clock,
	// control bits and pin
	input  wire logic        sw_write_enable,
	input  wire logic        program_setup,
	input  wire logic        program_pulse,
	input  wire logic        program_verify,
	input  wire logic        flash_write_enable_pin,
	// pulses needed before zeros stick
	input  wire logic [7:0]  stubborn,
	// flash bus
	input  wire logic [16:0] fl_addr,
	input  wire logic [7:0]  fl_wdata,
	input  wire logic        fl_wr,
	input  wire logic        fl_rd_word,
	output logic      [15:0] fl_rdata
);
	logic [7:0]  arr [0:131071];
	logic [7:0]  lat [0:127];
	logic [16:0] base = 17'h0;
	logic [16:0] vadr = 17'h0;
	logic        live = 1'b0;
	int          npul = 0;
	int          hold = 0;
	initial begin
		foreach (arr[i]) arr[i] = 8'hff;
		fl_rdata = 16'h0;
	end
	always @(posedge clock) begin
		if (fl_wr && sw_write_enable && !program_setup && !program_verify) begin
			lat[fl_addr[6:0]] <= fl_wdata;
			base <= {fl_addr[16:7], 7'h00};
		end
		if (fl_wr && program_verify) begin
			vadr <= fl_addr;
		end
		// pulse counts only with every enable up
		live <= program_pulse && program_setup && sw_write_enable && flash_write_enable_pin;
		if (!flash_write_enable_pin) begin
			npul <= 0;
		end else if (live && !program_pulse) begin
			npul <= npul + 1;
			if (npul + 1 >= int'(stubborn)) begin
				for (int i = 0; i < 128; i++) begin
					arr[base + 17'(i)] <= arr[base + 17'(i)] & lat[i];
				end
			end
		end
		// verify word, then the bus drifts
		if (fl_rd_word && program_verify) begin
			fl_rdata <= {arr[{vadr[16:1], 1'b0}], arr[{vadr[16:1], 1'b1}]};
			hold <= RD_LAT + 3;
		end else if (hold > 0) begin
			hold <= hold - 1;
		end else begin
			fl_rdata <= ~fl_rdata;
		end
	end
endmodule

//--- dv/tb.sv
// self-checking bench for the flash program/verify sequencer
`timescale 1ns/1ps
module tb;
	import fpvs_pkg::*;
	logic        clock, nrst, sw_wr, sw_rd, wen, setup, pul, vfy, pin_en, fl_wr, fl_rd;
	logic [8:0]  sw_addr;
	logic [31:0] sw_wdata, sw_rdata, st;
	logic [16:0] fl_addr;
	logic [15:0] fl_rdata;
	logic [7:0]  fl_wdata, stubborn;
	int          n_fail = 0;
	int          comparisons = 0;

	fpvs_sequencer #(.MAX_LOOPS(3), .RD_LAT(2)) i_fpvs_sequencer (
		.clock, .nrst, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
		.sw_write_enable(wen), .program_setup(setup), .program_pulse(pul),
		.program_verify(vfy), .erase_setup(), .erase_verify(), .flash_write_enable_pin(pin_en),
		.watchdog_timer_arm(), .watchdog_timer_period(), .fl_addr, .fl_wdata, .fl_wr,
		.fl_rd_word(fl_rd), .fl_rdata);
	fpvs_flash_model #(.RD_LAT(2)) i_fpvs_flash_model (
		.clock, .sw_write_enable(wen), .program_setup(setup), .program_pulse(pul),
		.program_verify(vfy), .flash_write_enable_pin(pin_en), .stubborn, .fl_addr,
		.fl_wdata, .fl_wr, .fl_rd_word(fl_rd), .fl_rdata);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// ------------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------------
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clock);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clock);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, output logic [31:0] d);
		@(posedge clock);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clock);
		sw_rd <= 1'b0;
		@(negedge clock);
		d = sw_rdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic run(input logic [16:0] pg, input logic [7:0] cnt, input logic [7:0] stb,
			input logic [7:0] pat);
		stubborn = stb;
		wr(REG_PAGE, {15'h0, pg});
		wr(REG_COUNT, {24'h0, cnt});
		for (int i = 0; i < 128; i++) begin
			wr(9'h100 | 9'(i), {24'h0, 8'(i) ^ pat});
		end
		wr(REG_CTRL, 32'h1);
		wr(REG_PAGE, 32'h200);
		st = 32'h1;
		for (int n = 0; n < 30000 && st[ST_BUSY_BIT] !== 1'b0; n++) begin
			rd(REG_STATUS, st);
		end
	endtask
	task automatic flash_is(input logic [16:0] pg, input int n, input logic [7:0] pat);
		logic [31:0] e;
		for (int i = 0; i < 128; i++) begin
			e = (i < n) ? {24'h0, 8'(i) ^ pat} : 32'hff;
			chk("flash byte", e, {24'h0, i_fpvs_flash_model.arr[pg + 17'(i)]});
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		sw_addr = 9'h000;
		sw_wdata = 32'h0;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		stubborn = 8'h01;
		nrst = 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		rd(REG_PAGE, st);
		chk("page reset", {15'h0, PAGE_RESET}, st);
		rd(REG_COUNT, st);
		chk("count reset", {24'h0, COUNT_RESET}, st);
		rd(9'h004, st);
		chk("unmapped", 32'h0, st);
		wr(9'h105, 32'hab);
		rd(9'h105, st);
		chk("data byte", 32'hab, st);
		run(17'h00080, 8'h00, 8'h01, 8'h5a);
		chk("status", 32'h2, st & 32'h7);
		chk("loops", 32'h1, st >> ST_LOOP_LSB);
		rd(REG_PAGE, st);
		chk("page held", 32'h80, st);
		chk("pin", 32'h0, {31'h0, pin_en});
		flash_is(17'h00080, 128, 8'h5a);
		run(17'h00100, 8'h05, 8'h03, 8'hc3);
		chk("status", 32'h2, st & 32'h7);
		chk("loops", 32'h2, st >> ST_LOOP_LSB);
		flash_is(17'h00100, 5, 8'hc3);
		run(17'h1ff80, 8'h00, 8'h32, 8'h0f);
		chk("status", 32'h4, st & 32'h7);
		chk("loops", 32'h3, st >> ST_LOOP_LSB);
		chk("pin", 32'h0, {31'h0, pin_en});
		flash_is(17'h1ff80, 0, 8'h0f);
		flash_is(17'h00080, 128, 8'h5a);
		wr(REG_PAGE, 32'h10);
		wr(REG_CTRL, 32'h1);
		rd(REG_STATUS, st);
		chk("bad page", 32'h8, st & 32'h9);
		chk("pin", 32'h0, {31'h0, pin_en});
		report_and_stop();
	end
	initial begin
		repeat (90000) @(posedge clock);
		n_fail++;
		report_and_stop();
	end
endmodule
